// ### pac_pkg.sv
// Package of register offsets, field layouts and reset values for the clock control block.
package pac_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_PLL_CONTROL = 8'h00;
  localparam logic [7:0] OFF_PLL_STATUS = 8'h04;
  localparam logic [7:0] OFF_PCLK0 = 8'h08;
  localparam logic [7:0] OFF_PCLK1 = 8'h0c;
  localparam logic [7:0] OFF_PCLK2 = 8'h10;
  localparam logic [7:0] OFF_PCLK3 = 8'h14;
  localparam logic [7:0] OFF_AUX_CONFIG = 8'h18;
  localparam logic [7:0] OFF_AUX_MULT = 8'h1c;
  localparam logic [7:0] OFF_AUX_STATUS = 8'h20;
  localparam logic [7:0] OFF_AUX_COUNT = 8'h24;
  localparam logic [7:0] OFF_PWM_CFG = 8'h28;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h2c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h30;
  // Field widths and limits.
  localparam int PLL_MULT_W = 5;
  localparam logic [4:0] PLL_MULT_MAX = 5'h10;
  localparam int AUX_MULT_W = 4;
  localparam int PLL_DIV_SELECT_W = 2;
  localparam int PCLK_W = 16;
  localparam int CNT_W = 32;
  // Aux config fields: bit 0 enable, bit 1 source (0 crystal, 1 internal).
  localparam int AUX_EN_BIT = 0;
  localparam int AUX_SRC_BIT = 1;
  localparam logic AUX_SRC_RESET = 1'b0;
  // Lock is reported after this many cycles of synchronised lock input held high while enabled.
  localparam int LOCK_CYCLES = 64;
  // Interrupt status bits.
  localparam int IRQ_LOCK_GAIN = 0;
  localparam int IRQ_LOCK_LOSS = 1;
  localparam int IRQ_CNT_WRAP = 2;
  localparam int IRQ_W = 3;
  // AXI responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Clock configuration seen by the clock tree.
  typedef struct packed {
    logic [4:0] pll_mult;
    logic [1:0] pll_div_select;
    logic aux_enable;
    logic aux_source;
    logic [3:0] aux_pll_multiplier;
  } pac_clk_cfg_s;
endpackage : pac_pkg

// ### pac_clock_control.sv
// Main and auxiliary PLL control, peripheral clock gates and PWM bus select behind AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module pac_clock_control (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Auxiliary PLL lock from the analog macro.
  input wire logic aux_pll_lock_in,
  // Auxiliary system clock tick, passed through a two-stage synchroniser here and counted on its rising edges.
  input wire logic aux_clk_tick,
  // Clock tree controls.
  output pac_pkg::pac_clk_cfg_s clk_cfg,
  output logic [pac_pkg::PCLK_W-1:0] periph_clock_enable_0,
  output logic [pac_pkg::PCLK_W-1:0] periph_clock_enable_1,
  output logic [pac_pkg::PCLK_W-1:0] periph_clock_enable_2,
  output logic [pac_pkg::PCLK_W-1:0] periph_clock_enable_3,
  output logic pwm_on_accel_bus,
  output logic aux_clk_gate,
  // Interrupt.
  output logic irq
);

  logic [4:0] pll_mult;
  logic [1:0] div_sel;
  logic [pac_pkg::PCLK_W-1:0] pclk0, pclk1, pclk2, pclk3;
  logic aux_en, aux_src;
  logic [3:0] aux_mult;
  logic pwm_sel;
  logic [pac_pkg::IRQ_W-1:0] irq_stat, irq_mask;
  logic [pac_pkg::CNT_W-1:0] aux_count;
  logic lock_meta, lock_sync, lock_flag;
  logic tick_meta, tick_sync, tick_prev;
  logic [6:0] lock_cnt;
  logic have_aw, have_w;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] wmask;
  logic tick_rise;
  logic cnt_wrap;
  logic lock_set, lock_clr;
  logic [31:0] next_rdata;
  logic next_rerr;

  // Write is performed once address and data have both been taken.
  assign do_write = have_aw && have_w && !s_axi_bvalid;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign tick_rise = tick_sync && !tick_prev;
  assign cnt_wrap = tick_rise && (aux_count == '1);
  assign lock_set = lock_flag == 1'b0 && lock_cnt == 7'(pac_pkg::LOCK_CYCLES) && aux_en;
  assign lock_clr = lock_flag && !(aux_en && lock_sync);

  // Address and data are taken independently and held until the write completes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !have_aw && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !have_w && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        have_aw <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        have_w <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
      end
    end
  end

  // Write response, error for unmapped or read-only addresses.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pac_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == pac_pkg::OFF_AUX_STATUS || aw_addr == pac_pkg::OFF_AUX_COUNT || aw_addr > pac_pkg::OFF_IRQ_MASK
          || aw_addr[1:0] != 2'h0)
        s_axi_bresp <= pac_pkg::RESP_SLVERR;
      else
        s_axi_bresp <= pac_pkg::RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Software-written configuration registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pll_mult <= 5'h00;
      div_sel <= 2'h0;
      pclk0 <= 16'h0000;
      pclk1 <= 16'h0000;
      pclk2 <= 16'h0000;
      pclk3 <= 16'h0000;
      aux_en <= 1'b0;
      aux_src <= pac_pkg::AUX_SRC_RESET;
      aux_mult <= 4'h0;
      pwm_sel <= 1'b0;
      irq_mask <= 3'h0;
    end
    else if (do_write)
    begin
      if (aw_addr == pac_pkg::OFF_PLL_CONTROL)
      begin
        // Settings above sixteen are ignored so the field always holds a legal multiplier.
        if (w_strb[0] && w_data[4:0] <= pac_pkg::PLL_MULT_MAX)
          pll_mult <= w_data[4:0];
      end
      else if (aw_addr == pac_pkg::OFF_PLL_STATUS)
      begin
        if (w_strb[0])
          div_sel <= w_data[1:0];
      end
      else if (aw_addr == pac_pkg::OFF_PCLK0)
        pclk0 <= (pclk0 & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
      else if (aw_addr == pac_pkg::OFF_PCLK1)
        pclk1 <= (pclk1 & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
      else if (aw_addr == pac_pkg::OFF_PCLK2)
        pclk2 <= (pclk2 & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
      else if (aw_addr == pac_pkg::OFF_PCLK3)
        pclk3 <= (pclk3 & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
      else if (aw_addr == pac_pkg::OFF_AUX_CONFIG)
      begin
        if (w_strb[0])
        begin
          aux_en <= w_data[pac_pkg::AUX_EN_BIT];
          aux_src <= w_data[pac_pkg::AUX_SRC_BIT];
        end
      end
      else if (aw_addr == pac_pkg::OFF_AUX_MULT)
      begin
        if (w_strb[0])
          aux_mult <= w_data[3:0];
      end
      else if (aw_addr == pac_pkg::OFF_PWM_CFG)
      begin
        if (w_strb[0])
          pwm_sel <= w_data[0];
      end
      else if (aw_addr == pac_pkg::OFF_IRQ_MASK)
      begin
        if (w_strb[0])
          irq_mask <= w_data[2:0];
      end
    end
  end

  // Two-stage synchronisers for the lock pin and the aux clock tick.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
      tick_meta <= 1'b0;
      tick_sync <= 1'b0;
      tick_prev <= 1'b0;
    end
    else
    begin
      lock_meta <= aux_pll_lock_in;
      lock_sync <= lock_meta;
      tick_meta <= aux_clk_tick;
      tick_sync <= tick_meta;
      tick_prev <= tick_sync;
    end
  end

  // Lock flag rises after the macro reports lock steadily while enabled.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lock_cnt <= 7'h00;
      lock_flag <= 1'b0;
    end
    else
    begin
      if (!(aux_en && lock_sync))
        lock_cnt <= 7'h00;
      else if (lock_cnt != 7'(pac_pkg::LOCK_CYCLES))
        lock_cnt <= lock_cnt + 7'h01;
      if (lock_clr)
        lock_flag <= 1'b0;
      else if (lock_set)
        lock_flag <= 1'b1;
    end
  end

  // Free-running count of aux clock edges, wrapping naturally at full scale.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aux_count <= 32'h0000_0000;
    else if (tick_rise)
      aux_count <= aux_count + 32'h0000_0001;
  end

  // Sticky event bits; a new event wins over a write-one clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat <= 3'h0;
    else
    begin
      irq_stat <= (irq_stat & ~((do_write && aw_addr == pac_pkg::OFF_IRQ_STATUS && w_strb[0]) ? w_data[2:0] : 3'h0))
                  | {cnt_wrap, lock_clr, lock_set};
    end
  end

  // Read data selection.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rerr = 1'b0;
    if (s_axi_araddr == pac_pkg::OFF_PLL_CONTROL)
      next_rdata = {27'h0, pll_mult};
    else if (s_axi_araddr == pac_pkg::OFF_PLL_STATUS)
      next_rdata = {30'h0, div_sel};
    else if (s_axi_araddr == pac_pkg::OFF_PCLK0)
      next_rdata = {16'h0, pclk0};
    else if (s_axi_araddr == pac_pkg::OFF_PCLK1)
      next_rdata = {16'h0, pclk1};
    else if (s_axi_araddr == pac_pkg::OFF_PCLK2)
      next_rdata = {16'h0, pclk2};
    else if (s_axi_araddr == pac_pkg::OFF_PCLK3)
      next_rdata = {16'h0, pclk3};
    else if (s_axi_araddr == pac_pkg::OFF_AUX_CONFIG)
      next_rdata = {30'h0, aux_src, aux_en};
    else if (s_axi_araddr == pac_pkg::OFF_AUX_MULT)
      next_rdata = {28'h0, aux_mult};
    else if (s_axi_araddr == pac_pkg::OFF_AUX_STATUS)
      next_rdata = {31'h0, lock_flag};
    else if (s_axi_araddr == pac_pkg::OFF_AUX_COUNT)
      next_rdata = aux_count;
    else if (s_axi_araddr == pac_pkg::OFF_PWM_CFG)
      next_rdata = {31'h0, pwm_sel};
    else if (s_axi_araddr == pac_pkg::OFF_IRQ_STATUS)
      next_rdata = {29'h0, irq_stat};
    else if (s_axi_araddr == pac_pkg::OFF_IRQ_MASK)
      next_rdata = {29'h0, irq_mask};
    else
      next_rerr = 1'b1;
  end

  // Read channel: address taken for one cycle, data follows on the next edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pac_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rerr ? pac_pkg::RESP_SLVERR : pac_pkg::RESP_OKAY;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Registered clock tree controls and interrupt.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clk_cfg <= '0;
      periph_clock_enable_0 <= 16'h0000;
      periph_clock_enable_1 <= 16'h0000;
      periph_clock_enable_2 <= 16'h0000;
      periph_clock_enable_3 <= 16'h0000;
      pwm_on_accel_bus <= 1'b0;
      aux_clk_gate <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      clk_cfg <= '{pll_mult: pll_mult, pll_div_select: div_sel, aux_enable: aux_en,
                   aux_source: aux_src, aux_pll_multiplier: aux_mult};
      periph_clock_enable_0 <= pclk0;
      periph_clock_enable_1 <= pclk1;
      periph_clock_enable_2 <= pclk2;
      periph_clock_enable_3 <= pclk3;
      pwm_on_accel_bus <= pwm_sel;
      // Aux clock reaches capture and USB only once the second PLL is locked.
      aux_clk_gate <= aux_en && lock_flag;
      irq <= |(irq_stat & irq_mask);
    end
  end

endmodule : pac_clock_control
`default_nettype wire

// ### pac_clock_control_sva.sv
// Checker of bus handshakes and clock control outputs.
`timescale 1ns/100ps
`default_nettype none
module pac_clock_control_sva (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus signals.
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Clock tree side.
  input wire logic aux_pll_lock_in,
  input wire pac_pkg::pac_clk_cfg_s clk_cfg,
  input wire logic [pac_pkg::PCLK_W-1:0] periph_clock_enable_0,
  input wire logic [pac_pkg::PCLK_W-1:0] periph_clock_enable_1,
  input wire logic [pac_pkg::PCLK_W-1:0] periph_clock_enable_2,
  input wire logic [pac_pkg::PCLK_W-1:0] periph_clock_enable_3,
  input wire logic pwm_on_accel_bus,
  input wire logic aux_clk_gate
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Answers stand until taken, and the address ready is a single pulse.
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready longer than a pulse");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h30 || s_axi_araddr[1:0] != 2'h0)
    |=> s_axi_rresp == pac_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read not refused");
  // Configuration outputs move only in the cycle after a write response has been raised.
  cfg_on_write_a: assert property ($past(aresetn) && $changed({clk_cfg, periph_clock_enable_0, periph_clock_enable_1,
    periph_clock_enable_2, periph_clock_enable_3, pwm_on_accel_bus}) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("config moved");
  mult_limit_a: assert property (clk_cfg.pll_mult <= pac_pkg::PLL_MULT_MAX) else $error("pll multiplier above limit");
  // The aux gate needs a lasting enable and lock.
  gate_cause_a: assert property ($rose(aux_clk_gate) |-> $past(clk_cfg.aux_enable, 8) && $past(aux_pll_lock_in, 8))
    else $error("aux gate opened without lock");
  gate_off_a: assert property (!clk_cfg.aux_enable [*3] |-> !aux_clk_gate) else $error("aux gate open while off");
endmodule : pac_clock_control_sva
bind pac_clock_control pac_clock_control_sva chk (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .aux_pll_lock_in, .clk_cfg, .periph_clock_enable_0, .periph_clock_enable_1, .periph_clock_enable_2,
  .periph_clock_enable_3, .pwm_on_accel_bus, .aux_clk_gate);
`default_nettype wire

// ### pac_clock_control_tb.sv
// Self-checking bench of the clock control block.
`timescale 1ns/100ps
`default_nettype none
module pac_clock_control_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic aux_pll_lock_in, aux_clk_tick, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic pwm_on_accel_bus, aux_clk_gate, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v, e, c0;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] periph_clock_enable_0, periph_clock_enable_1, periph_clock_enable_2, periph_clock_enable_3;
  pac_pkg::pac_clk_cfg_s clk_cfg;
  int fail_count, n_compared, i, n;
  integer seed;
  localparam logic [1:0] OK = pac_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = pac_pkg::RESP_SLVERR;
  wire logic [63:0] pe = {periph_clock_enable_3, periph_clock_enable_2, periph_clock_enable_1, periph_clock_enable_0};
  // Design under test.
  pac_clock_control uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .aux_pll_lock_in, .aux_clk_tick,
    .clk_cfg, .periph_clock_enable_0, .periph_clock_enable_1, .periph_clock_enable_2, .periph_clock_enable_3,
    .pwm_on_accel_bus, .aux_clk_gate, .irq);
  // Clock of 100 ns period.
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Prints the counts and the verdict, then stops.
  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // Compares one value and reports a mismatch.
  task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : check
  // Byte-strobe merge of a 16-bit enable register.
  function automatic logic [15:0] merge(input logic [15:0] o, input logic [31:0] d, input logic [3:0] s);
    return {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction : merge
  // Multiplier kept when the written value is out of range.
  function automatic logic [31:0] next_mult(input logic [31:0] o, input logic [31:0] d);
    return (d > 32'h10) ? o : d;
  endfunction : next_mult
  // One bus write, with its response checked.
  task automatic wc(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] rx);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    check("bresp", 32'(rx), 32'(s_axi_bresp));
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wc
  // One bus read.
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // Read with data and response checked.
  task automatic rc(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] rx);
    logic [31:0] d;
    logic [1:0] rs;
    rd(a, d, rs);
    check("rdata", ex, d);
    check("rresp", 32'(rx), 32'(rs));
  endtask : rc
  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    give_verdict();
  end
  // Main sequence.
  initial
  begin
    seed = 32'h4ae1;
    fail_count = 0;
    n_compared = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aux_pll_lock_in} <= 7'h0;
    {aux_clk_tick, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= 53'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("clk_cfg", 32'h0, 32'(clk_cfg));
    rc(pac_pkg::OFF_AUX_CONFIG, 32'h0, OK);
    e = 32'h0;
    for (i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 32'h10 : (i == 1) ? 32'h11 : $random(seed) & 32'h1f;
      wc(pac_pkg::OFF_PLL_CONTROL, v, 4'hf, OK);
      e = next_mult(e, v);
      check("pll_mult", e, 32'(clk_cfg.pll_mult));
      rc(pac_pkg::OFF_PLL_CONTROL, e, OK);
    end
    v = $random(seed) & 32'h3;
    wc(pac_pkg::OFF_PLL_STATUS, v, 4'hf, OK);
    check("div_select", v, 32'(clk_cfg.pll_div_select));
    for (i = 0; i < 4; i++)
    begin
      v = $random(seed);
      e = {16'h0, v[15:0]};
      wc(8'(pac_pkg::OFF_PCLK0 + 4 * i), v, 4'hf, OK);
      v = $random(seed);
      e = {16'h0, merge(e[15:0], v, 4'(i))};
      wc(8'(pac_pkg::OFF_PCLK0 + 4 * i), v, 4'(i), OK);
      check("pclk", e, 32'(pe[i*16+:16]));
      rc(8'(pac_pkg::OFF_PCLK0 + 4 * i), e, OK);
    end
    v = $random(seed);
    wc(pac_pkg::OFF_AUX_MULT, v, 4'hf, OK);
    check("aux_mult", {28'h0, v[3:0]}, 32'(clk_cfg.aux_pll_multiplier));
    for (i = 1; i >= 0; i--)
    begin
      wc(pac_pkg::OFF_PWM_CFG, 32'(i), 4'hf, OK);
      check("pwm_bus", 32'(i), 32'(pwm_on_accel_bus));
    end
    wc(pac_pkg::OFF_AUX_CONFIG, 32'h3, 4'h1, OK);
    check("aux_cfg", 32'h3, 32'({clk_cfg.aux_source, clk_cfg.aux_enable}));
    aux_pll_lock_in <= 1'b1;
    repeat (80) @(posedge aclk);
    rc(pac_pkg::OFF_AUX_STATUS, 32'h1, OK);
    check("gate", 32'h1, 32'(aux_clk_gate));
    check("irq", 32'h0, 32'(irq));
    wc(pac_pkg::OFF_AUX_STATUS, 32'h0, 4'hf, ERR);
    rc(pac_pkg::OFF_AUX_STATUS, 32'h1, OK);
    rc(pac_pkg::OFF_IRQ_STATUS, 32'h1, OK);
    wc(pac_pkg::OFF_IRQ_MASK, 32'h1, 4'hf, OK);
    repeat (2) @(posedge aclk);
    check("irq", 32'h1, 32'(irq));
    wc(pac_pkg::OFF_IRQ_STATUS, 32'h1, 4'hf, OK);
    repeat (2) @(posedge aclk);
    check("irq", 32'h0, 32'(irq));
    aux_pll_lock_in <= 1'b0;
    repeat (8) @(posedge aclk);
    check("gate", 32'h0, 32'(aux_clk_gate));
    rc(pac_pkg::OFF_IRQ_STATUS, 32'h2, OK);
    rd(pac_pkg::OFF_AUX_COUNT, c0, r);
    n = 1 + ($random(seed) & 15);
    repeat (n)
    begin
      aux_clk_tick <= 1'b1;
      repeat (3) @(posedge aclk);
      aux_clk_tick <= 1'b0;
      repeat (3) @(posedge aclk);
    end
    rc(pac_pkg::OFF_AUX_COUNT, c0 + 32'(n), OK);
    rc(8'h34, 32'h0, ERR);
    wc(8'h02, 32'h1, 4'hf, ERR);
    // A reset in mid-run clears every control output, the count and the configuration.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check("cfg_rst", 32'h0, 32'(clk_cfg));
    check("pclk_rst", 32'h0, pe[31:0] | pe[63:32]);
    check("gate_rst", 32'h0, 32'({pwm_on_accel_bus, aux_clk_gate, irq}));
    rc(pac_pkg::OFF_AUX_COUNT, 32'h0, OK);
    rc(pac_pkg::OFF_AUX_CONFIG, 32'h0, OK);
    give_verdict();
  end
endmodule : pac_clock_control_tb
`default_nettype wire
